// >>> verilog/ds3_e3_tx_framer.sv
// one transmit framer channel: system side timing, line coding, apb registers
`timescale 1ns/1ns
`default_nettype none
// Contract
// - bipolar mode applies B3ZS or HDB3 substitution, marks on both rails
// - AMI mode alternates marks on both rails, never substitutes
// - NRZ mode sends unipolar data on positive rail, negative rail idle
// - each line bit lasts one line clock; edge select picks rising or falling
// - overhead clock pulses once per overhead bit allocated to the pin
// - overhead input sampled at tx clock fall after overhead clock pulse
// - gapped clock stops at overhead not carried with payload; both invertible
// - sync input enabled: pin is input, sampled on tx clock falling edge
// - alignment from last sync pulse held indefinitely
// - sync at predicted place keeps alignment, elsewhere forces realignment
// - realignment completes within one frame period
// - before first sync pulse both clocks held off as one long gap
// - sync sampled high after low marks same-edge payload bit as frame bit one
// - sync output enabled: pin driven, updated on tx clock rising edge
// - marker select 0: automatic frame start, rising between frames
// - marker select 1: low on every overhead bit, high on payload
// - DS3 frame start output falls after M3 of subframe 7
// - sync pin floats after reset until configured
// - G.751 frame start output falls after C11
module ds3_e3_tx_framer
    import tx_framer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tx_framer_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    input wire logic tx_input_clock,
    input wire logic tx_serial_payload_in,
    input wire logic ext_overhead_in,
    output logic gapped_payload_clock,
    output logic ext_overhead_clock,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe_n,
    // line side
    output logic line_pos_rail_out,
    output logic line_neg_rail_out,
    output logic line_clock_out
);
    import tx_framer_pkg::*;

    // overhead class of a bit position
    function automatic ovh_group_t ovhGroup(input logic fmt, input logic [2:0] sf,
            input logic [2:0] blk, input logic [8:0] bitIdx, input logic febeExt);
        ovh_group_t g;
        g = GRP_NONE;
        if (fmt == FMT_DS3) begin
            if (bitIdx == 9'h000) begin
                if (blk == 3'h0) begin
                    if (sf < 3'h2) begin
                        g = GRP_ALARM;
                    end else if (sf < 3'h4) begin
                        g = GRP_PARITY;
                    end else begin
                        g = GRP_FRAME;
                    end
                end else if (blk[0]) begin
                    g = GRP_FRAME;
                end else if (sf == DS3_FEBE_SF && febeExt) begin
                    g = GRP_FEBE;
                end else begin
                    g = GRP_JUST;
                end
            end else if (blk == DS3_LAST_BLK && bitIdx == 9'h001) begin
                g = GRP_STUFF;
            end
        end else begin
            if (blk == 3'h0) begin
                if (bitIdx < E3_FAS_BITS) begin
                    g = GRP_FRAME;
                end else if (bitIdx < E3_FAS_BITS + 9'h002) begin
                    g = GRP_ALARM;
                end
            end else if (bitIdx < E3_JUST_BITS) begin
                g = GRP_JUST;
            end else if (blk == E3_LAST_SET && bitIdx < E3_STUFF_END) begin
                g = GRP_STUFF;
            end
        end
        return g;
    endfunction

    // value of an internally generated overhead bit
    function automatic logic ovhValue(input logic fmt, input logic [2:0] sf,
            input logic [2:0] blk, input logic [8:0] bitIdx);
        logic v;
        v = 1'b0;
        if (fmt == FMT_DS3) begin
            if (blk == 3'h0) begin
                v = (sf < 3'h2) || (sf == 3'h5);
            end else if (blk[0]) begin
                v = (blk == 3'h1) || (blk == 3'h7);
            end
        end else if (blk == 3'h0 && bitIdx < E3_FAS_BITS) begin
            v = E3_FAS_WORD[4'(9 - bitIdx)];
        end else if (blk == 3'h0 && bitIdx == E3_FAS_BITS + 9'h001) begin
            v = 1'b1;
        end
        return v;
    endfunction

    function automatic logic allocated(input logic [ALLOC_W-1:0] mask, input ovh_group_t g);
        return (g != GRP_NONE) && mask[3'(g - GRP_FRAME)];
    endfunction

    // configuration, one copy per channel instance
    logic [31:0] ctrl;
    logic fmt;
    line_code_t lineCode;
    logic edgeSel, syncInEn, syncOutEn, markSel, gapInv, extInv, febeExt;
    logic [ALLOC_W-1:0] extAlloc, payAlloc;
    assign fmt = ctrl[CB_FMT];
    assign lineCode = line_code_t'(ctrl[CB_CODE+:2]);
    assign edgeSel = ctrl[CB_EDGE];
    assign syncInEn = ctrl[CB_SYIN];
    assign syncOutEn = ctrl[CB_SYOUT] & ~ctrl[CB_SYIN];
    assign markSel = ctrl[CB_MARK];
    assign gapInv = ctrl[CB_GINV];
    assign extInv = ctrl[CB_XINV];
    assign febeExt = ctrl[CB_FEBE];
    assign extAlloc = ctrl[CB_XALLOC+:ALLOC_W];
    assign payAlloc = ctrl[CB_PALLOC+:ALLOC_W];

    // pin synchronisers: first stage feeds only the second
    logic [3:0] pinMeta, pinSync;
    logic clkPrev, syncSampled;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
        end else begin
            pinMeta <= {frame_sync_pin_in, ext_overhead_in, tx_serial_payload_in,
                tx_input_clock};
            pinSync <= pinMeta;
        end
    end
    logic txClk, txRise, txFall, lineEdge;
    assign txClk = pinSync[0];
    assign txRise = txClk & ~clkPrev;
    assign txFall = ~txClk & clkPrev;
    assign lineEdge = edgeSel ? txFall : txRise;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkPrev <= 1'b0;
            line_clock_out <= 1'b0;
        end else begin
            clkPrev <= txClk;
            line_clock_out <= txClk;
        end
    end

    // frame position of the bit sampled at the next falling edge
    logic [2:0] posSf, posBlk;
    logic [8:0] posBit;
    logic [2:0] next_posSf, next_posBlk;
    logic [8:0] next_posBit;
    always_comb begin
        next_posSf = posSf;
        next_posBlk = posBlk;
        next_posBit = posBit + 9'h001;
        if (posBit == (fmt == FMT_DS3 ? DS3_LAST_BIT : E3_LAST_BIT)) begin
            next_posBit = 9'h000;
            next_posBlk = posBlk + 3'h1;
            if (posBlk == (fmt == FMT_DS3 ? DS3_LAST_BLK : E3_LAST_SET)) begin
                next_posBlk = 3'h0;
                next_posSf = (fmt == FMT_DS3 && posSf != DS3_LAST_SF) ? posSf + 3'h1 : 3'h0;
            end
        end
    end

    ovh_group_t grp;
    logic atStart;
    assign grp = ovhGroup(fmt, posSf, posBlk, posBit, febeExt);
    assign atStart = (posSf == 3'h0) && (posBlk == 3'h0) && (posBit == 9'h000);

    // sync input tracking
    sync_state_t syncState;
    logic syncRise, realigned;
    assign syncRise = syncInEn & txFall & pinSync[3] & ~syncSampled;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncSampled <= 1'b1;
        end else if (txFall) begin
            syncSampled <= pinSync[3];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncState <= SYNC_WAIT;
        end else begin
            case (syncState)
                SYNC_WAIT: begin
                    if (syncRise) begin
                        syncState <= SYNC_LOCKED;
                    end
                end
                SYNC_LOCKED: begin
                    // held with no further pulses while input mode stays on
                    if (!syncInEn) begin
                        syncState <= SYNC_WAIT;
                    end
                end
                default: syncState <= SYNC_WAIT;
            endcase
        end
    end

    logic running;
    assign running = !syncInEn || (syncState == SYNC_LOCKED);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            posSf <= 3'h0;
            posBlk <= 3'h0;
            posBit <= 9'h000;
        end else if (syncRise) begin
            // bit taken at this edge is frame bit one
            // at the predicted place this equals the free-run step
            // and a foreign place realigns at once, well inside a frame
            posSf <= 3'h0;
            posBlk <= 3'h0;
            posBit <= 9'h001;
        end else if (txFall && running) begin
            posSf <= next_posSf;
            posBlk <= next_posBlk;
            posBit <= next_posBit;
        end
    end

    // realignment event from a misplaced pulse
    assign realigned = syncRise && (syncState == SYNC_LOCKED) && !atStart;

    // bit selection at the falling edge
    logic txBit;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txBit <= 1'b0;
        end else if (txFall) begin
            if (grp == GRP_NONE || allocated(payAlloc, grp)) begin
                txBit <= pinSync[1];
            end else if (allocated(extAlloc, grp)) begin
                txBit <= pinSync[2];
            end else begin
                txBit <= ovhValue(fmt, posSf, posBlk, posBit);
            end
        end
    end

    // gapped and overhead clocks follow the tx clock through a gate
    logic payGate, extGate;
    assign payGate = running && (grp == GRP_NONE || allocated(payAlloc, grp));
    assign extGate = running && allocated(extAlloc, grp) && !allocated(payAlloc, grp);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gapped_payload_clock <= 1'b0;
            ext_overhead_clock <= 1'b0;
        end else begin
            gapped_payload_clock <= (txClk & payGate) ^ gapInv;
            ext_overhead_clock <= (txClk & extGate) ^ extInv;
        end
    end

    // sync output, floating until a direction is chosen
    logic frameHigh;
    always_comb begin
        if (fmt == FMT_DS3) begin
            frameHigh = (posSf < DS3_LAST_SF) || (posBlk == 3'h0 && posBit == 9'h000);
        end else begin
            frameHigh = (posBlk == 3'h0) || (posBlk == 3'h1 && posBit == 9'h000);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frame_sync_pin_out <= 1'b0;
            frame_sync_pin_oe_n <= 1'b1;
        end else begin
            frame_sync_pin_oe_n <= ~syncOutEn;
            if (txRise) begin
                // marker mode low on all overhead, frame mode high through frame head
                frame_sync_pin_out <= markSel ? (grp == GRP_NONE) : frameHigh;
            end
        end
    end

    // line coder: four-stage look-ahead so a zero run can be rewritten
    mark_t encPipe [4];
    logic bParity, lastNeg, runZero, subst, insertB, negNow;
    assign runZero = !txBit && encPipe[0] == MK_ZERO && encPipe[1] == MK_ZERO
        && (fmt == FMT_DS3 || encPipe[2] == MK_ZERO);
    assign subst = (lineCode == CODE_BIPOLAR) && runZero;
    assign insertB = subst && !bParity;
    assign negNow = (encPipe[3] == MK_VIOL) ? lastNeg : ~lastNeg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                encPipe[i] <= MK_ZERO;
            end
            bParity <= 1'b0;
        end else if (lineEdge) begin
            encPipe[0] <= subst ? MK_VIOL : (txBit ? MK_PULSE : MK_ZERO);
            encPipe[1] <= encPipe[0];
            encPipe[2] <= (insertB && fmt == FMT_DS3) ? MK_PULSE : encPipe[1];
            encPipe[3] <= (insertB && fmt == FMT_E3) ? MK_PULSE : encPipe[2];
            bParity <= subst ? 1'b0 : bParity ^ txBit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            line_pos_rail_out <= 1'b0;
            line_neg_rail_out <= 1'b0;
            lastNeg <= 1'b1;
        end else if (lineEdge) begin
            if (lineCode == CODE_NRZ) begin
                line_pos_rail_out <= encPipe[3] != MK_ZERO;
                line_neg_rail_out <= 1'b0;
            end else begin
                line_pos_rail_out <= encPipe[3] != MK_ZERO && !negNow;
                line_neg_rail_out <= encPipe[3] != MK_ZERO && negNow;
                if (encPipe[3] != MK_ZERO) begin
                    lastNeg <= negNow;
                end
            end
        end
    end

    // apb slave, zero wait states
    logic apbAccess, apbWrite, hitCtrl, hitStatus, hitPos;
    logic realignSticky;
    assign apbAccess = psel & penable;
    assign apbWrite = apbAccess & pwrite;
    assign hitCtrl = paddr == OFS_CTRL;
    assign hitStatus = paddr == OFS_STATUS;
    assign hitPos = paddr == OFS_POS;
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~(hitCtrl | hitStatus | hitPos);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (apbWrite && hitCtrl) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    ctrl[i*8+:8] <= pwdata[i*8+:8];
                end
            end
        end
    end

    // a new realignment in the clearing cycle keeps the flag set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            realignSticky <= 1'b0;
        end else if (realigned) begin
            realignSticky <= 1'b1;
        end else if (apbWrite && hitStatus && pstrb[0] && pwdata[SB_REALIGN]) begin
            realignSticky <= 1'b0;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (apbAccess && !pwrite) begin
            if (hitCtrl) begin
                prdata = ctrl;
            end else if (hitStatus) begin
                prdata[SB_SYNCED] = running;
                prdata[SB_REALIGN] = realignSticky;
                prdata[SB_DRIVING] = ~frame_sync_pin_oe_n;
            end else if (hitPos) begin
                prdata[8:0] = posBit;
                prdata[18:16] = posBlk;
                prdata[26:24] = posSf;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/tx_framer_pkg.sv
// constants and types shared by the transmit framer channel
`default_nettype none
package tx_framer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    // control word fields
    localparam int CB_FMT = 0;
    localparam int CB_CODE = 1;
    localparam int CB_EDGE = 3;
    localparam int CB_SYIN = 4;
    localparam int CB_SYOUT = 5;
    localparam int CB_MARK = 6;
    localparam int CB_GINV = 7;
    localparam int CB_XINV = 8;
    localparam int CB_FEBE = 9;
    localparam int CB_XALLOC = 16;
    localparam int CB_PALLOC = 24;
    localparam int ALLOC_W = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status fields
    localparam int SB_SYNCED = 0;
    localparam int SB_REALIGN = 1;
    localparam int SB_DRIVING = 2;
    // frame geometry
    localparam logic [2:0] DS3_LAST_SF = 3'h6;
    localparam logic [2:0] DS3_LAST_BLK = 3'h7;
    localparam logic [8:0] DS3_LAST_BIT = 9'h054;
    localparam logic [2:0] E3_LAST_SET = 3'h3;
    localparam logic [8:0] E3_LAST_BIT = 9'h17F;
    localparam logic [8:0] E3_FAS_BITS = 9'h00A;
    localparam logic [8:0] E3_JUST_BITS = 9'h004;
    localparam logic [8:0] E3_STUFF_END = 9'h008;
    localparam logic [9:0] E3_FAS_WORD = 10'h3D0;
    localparam logic [2:0] DS3_FEBE_SF = 3'h3;
    typedef enum logic {FMT_DS3 = 1'b0, FMT_E3 = 1'b1} frame_fmt_t;
    typedef enum logic [1:0] {
        CODE_BIPOLAR = 2'h0,
        CODE_AMI = 2'h1,
        CODE_NRZ = 2'h2
    } line_code_t;
    typedef enum logic [2:0] {
        GRP_NONE = 3'h0,
        GRP_FRAME = 3'h1,
        GRP_ALARM = 3'h2,
        GRP_PARITY = 3'h3,
        GRP_JUST = 3'h4,
        GRP_STUFF = 3'h5,
        GRP_FEBE = 3'h6
    } ovh_group_t;
    typedef enum logic [1:0] {
        MK_ZERO = 2'h0,
        MK_PULSE = 2'h1,
        MK_VIOL = 2'h2
    } mark_t;
    typedef enum logic [1:0] {SYNC_WAIT = 2'h0, SYNC_LOCKED = 2'h1} sync_state_t;
endpackage
`default_nettype wire

// >>> test/tx_framer_properties.sv
// concurrent checks on the transmit framer channel ports
`timescale 1ns/1ns
`default_nettype none
module tx_framer_properties (
    // clock, reset and apb
    input wire logic sys_clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [tx_framer_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    // system and line side
    input wire logic tx_input_clock, tx_serial_payload_in, ext_overhead_in,
    input wire logic gapped_payload_clock, ext_overhead_clock, frame_sync_pin_in,
    input wire logic frame_sync_pin_out, frame_sync_pin_oe_n,
    input wire logic line_pos_rail_out, line_neg_rail_out, line_clock_out
);
    import tx_framer_pkg::*;
    logic [31:0] ctrl;
    logic [7:0] age;
    logic seenSync;
    logic settled;
    assign settled = age == 8'hFF;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // control word copy; age masks the lag after a write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
            age <= 8'h00;
        end else if (psel && penable && pwrite && paddr == OFS_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    ctrl[8*i+:8] <= pwdata[8*i+:8];
                end
            end
            age <= 8'h00;
        end else if (!settled) begin
            age <= age + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !ctrl[CB_SYIN]) begin
            seenSync <= 1'b0;
        end else if (frame_sync_pin_in) begin
            seenSync <= 1'b1;
        end
    end
    sequence s_rail_step;
        $changed(line_pos_rail_out) || $changed(line_neg_rail_out);
    endsequence
    a_reset_floats: assert property ($fell(rst) |-> frame_sync_pin_oe_n)
        else $error("sync pin driven after reset");
    a_idle_floats: assert property (settled && ctrl[5:4] == 2'h0 |-> frame_sync_pin_oe_n)
        else $error("sync pin driven while unconfigured");
    a_pin_input: assert property (settled && ctrl[CB_SYIN] |-> frame_sync_pin_oe_n)
        else $error("sync pin driven in input mode");
    a_pin_driven: assert property (settled && ctrl[5:4] == 2'h2 |-> !frame_sync_pin_oe_n)
        else $error("sync pin not driven in output mode");
    a_rails_exclusive: assert property (!(line_pos_rail_out && line_neg_rail_out))
        else $error("both rails marked at once");
    a_nrz_neg_idle: assert property (settled && ctrl[2:1] == CODE_NRZ |-> !line_neg_rail_out)
        else $error("negative rail active in nrz");
    a_line_edge: assert property (settled ##0 s_rail_step |->
        (ctrl[CB_EDGE] ? $fell(line_clock_out) : $rose(line_clock_out)))
        else $error("rails changed off the selected line clock edge");
    a_wait_gap: assert property (settled && ctrl[CB_SYIN] && !seenSync |->
        gapped_payload_clock == ctrl[CB_GINV] && ext_overhead_clock == ctrl[CB_XINV])
        else $error("clocks ran before first sync");
    a_ext_idle: assert property (settled && ctrl[21:16] == 6'h00 && !ctrl[CB_FEBE] |->
        ext_overhead_clock == ctrl[CB_XINV])
        else $error("overhead clock pulsed with nothing on the pin");
    a_mark_payload: assert property (settled && ctrl[6:4] == 3'h6 && ctrl[29:24] == 6'h00
        && !ctrl[CB_GINV] && $rose(gapped_payload_clock) |-> frame_sync_pin_out)
        else $error("marker low on a payload bit");
endmodule
bind ds3_e3_tx_framer tx_framer_properties chk (.*);
`default_nettype wire

// >>> test/tx_system_model.sv
// system side partner: transmit clock, serial payload, overhead bits, sync pulses
`timescale 1ns/1ns
`default_nettype none
module tx_system_model (
    // requests from the bench
    input wire logic zeroPayload,
    input wire logic syncReq,
    // system side pins
    output logic txClk,
    output logic payload,
    output logic extBit,
    output logic syncIn
);
    int step;
    initial begin
        txClk = 1'b0;
        payload = 1'b0;
        extBit = 1'b0;
        syncIn = 1'b0;
        step = 0;
        // offset keeps both edges off the system clock edges
        #2;
        forever begin
            txClk = 1'b1;
            #62;
            txClk = 1'b0;
            #63;
        end
    end
    // bits launched at the rise so they are settled at the sampling fall
    always @(posedge txClk) begin
        payload <= zeroPayload ? 1'b0 : 1'($urandom);
        extBit <= 1'($urandom);
        if (!syncReq) begin
            step <= 0;
        end else if (step < 3) begin
            step <= step + 1;
        end
        // low for a bit first, then high for two clocks
        syncIn <= syncReq && step >= 1 && step < 3;
    end
endmodule
`default_nettype wire

// >>> test/ds3_e3_tx_framer_interface_tb_top.sv
// self-checking bench for the transmit framer channel
`timescale 1ns/1ns
`default_nettype none
module ds3_e3_tx_framer_interface_tb_top;
    import tx_framer_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, se;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [3:0] pstrb;
    logic txClk, payload, extBit, syncIn, zeroPayload, syncReq, syncPin;
    logic gapClk, extClk, syncOut, syncOeN, posRail, negRail, lineClk;
    int err_total, total_checks, a, b, c, d;
    assign syncPin = syncOeN ? syncIn : syncOut;
    tx_system_model partner (.zeroPayload(zeroPayload), .syncReq(syncReq), .txClk(txClk),
        .payload(payload), .extBit(extBit), .syncIn(syncIn));
    ds3_e3_tx_framer dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_input_clock(txClk),
        .tx_serial_payload_in(payload), .ext_overhead_in(extBit),
        .gapped_payload_clock(gapClk), .ext_overhead_clock(extClk),
        .frame_sync_pin_in(syncPin), .frame_sync_pin_out(syncOut),
        .frame_sync_pin_oe_n(syncOeN), .line_pos_rail_out(posRail),
        .line_neg_rail_out(negRail), .line_clock_out(lineClk));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // counts marks per rail and repeated polarities at the selected line edge
    task automatic lineRun(input logic [31:0] cfg, input logic zeros,
        output int pm, output int nm, output int alt);
        logic lastNeg, prevClk;
        int bits;
        zeroPayload <= zeros;
        // zero runs: all overhead rides with the payload so the line sees only zeros
        apb(1'b1, OFS_CTRL, cfg | {2'h0, {6{zeros}}, 24'h0});
        {pm, nm, alt, bits} = '0;
        lastNeg = 1'b0;
        repeat (400) @(posedge sys_clk);
        prevClk = lineClk;
        while (bits < 96) begin
            @(posedge sys_clk);
            if (lineClk !== prevClk && lineClk === !cfg[CB_EDGE]) begin
                bits++;
                if (posRail === 1'b1 || negRail === 1'b1) begin
                    if (pm + nm > 0 && negRail === lastNeg) alt++;
                    lastNeg = negRail;
                    pm += posRail;
                    nm += negRail;
                end
            end
            prevClk = lineClk;
        end
        $display("line test done cfg %h", cfg);
    endtask
    // one frame measured from a sync output rise to the next
    task automatic frameRun(output int gaps, output int exts, output int wide, output int len);
        logic pS, pG, pE, pT;
        int state;
        {gaps, exts, wide, len, state} = '0;
        {pS, pG, pE, pT} = {syncOut, gapClk, extClk, txClk};
        while (state < 2) begin
            @(posedge sys_clk);
            if (syncOut === 1'b1 && pS === 1'b0) state++;
            if (state == 1) begin
                gaps += (gapClk && !pG);
                exts += (extClk && !pE);
                len += (pT && !txClk);
                wide += (pT && !txClk && syncOut);
            end
            {pS, pG, pE, pT} = {syncOut, gapClk, extClk, txClk};
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(32'h7580));
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        zeroPayload = 1'b0;
        syncReq = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("sync pin float", 1, syncOeN);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", CTRL_RESET, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 1, se);
        chk("unmapped data", 0, rd);
        repeat (4) begin
            w = $urandom & 32'h3F3F03FF;
            apb(1'b1, OFS_CTRL, w);
            apb(1'b0, OFS_CTRL, 32'h0);
            chk("ctrl readback", w, rd);
        end
        $display("register test done");
        lineRun((32'(CODE_NRZ) << CB_CODE) | (32'h1 << CB_XINV), 1'b0, a, b, c);
        chk("nrz negative marks", 0, b);
        chk("nrz data present", 1, a > 0);
        lineRun((32'(CODE_AMI) << CB_CODE) | (32'h1 << CB_EDGE), 1'b0, a, b, c);
        chk("ami alternation faults", 0, c);
        lineRun(32'(CODE_AMI) << CB_CODE, 1'b1, a, b, c);
        chk("ami marks on zeros", 0, a + b);
        for (int f = 0; f < 2; f++) begin
            lineRun(32'(f), 1'b1, a, b, c);
            chk("bipolar marks on zeros", 1, a > 0 && b > 0);
            chk("bipolar violations", 1, c > 0);
        end
        zeroPayload <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h1 | (32'h1 << CB_SYOUT) | (32'h1 << CB_XALLOC));
        frameRun(a, b, c, d);
        chk("sync pin driven", 0, syncOeN);
        chk("overhead clock pulses", E3_FAS_BITS, b);
        chk("gapped pulses", 4 * (E3_LAST_BIT + 1) - E3_FAS_BITS - 2 - 3 * E3_JUST_BITS
            - (E3_STUFF_END - E3_JUST_BITS), a);
        chk("frame start width", E3_LAST_BIT + 2, c);
        chk("frame start period", 4 * (E3_LAST_BIT + 1), d);
        $display("frame test done");
        apb(1'b1, OFS_CTRL, 32'h1 | (32'h1 << CB_SYOUT) | (32'h1 << CB_MARK));
        repeat (3000) @(posedge sys_clk);
        apb(1'b1, OFS_CTRL, 32'h1 | (32'h1 << CB_SYIN) | (32'h1 << CB_GINV));
        repeat (1200) @(posedge sys_clk);
        chk("sync pin input", 1, syncOeN);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("running before sync", 0, rd[SB_SYNCED]);
        syncReq <= 1'b1;
        a = 0;
        w[0] = gapClk;
        repeat (800) begin
            @(posedge sys_clk);
            a += (gapClk !== w[0]);
            w[0] = gapClk;
        end
        chk("gapped after sync", 1, a > 0);
        apb(1'b1, OFS_STATUS, 32'h2);
        repeat (1200) @(posedge sys_clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("alignment held", 2'h1, rd[1:0]);
        syncReq <= 1'b0;
        repeat (40) @(posedge sys_clk);
        syncReq <= 1'b1;
        repeat (600) @(posedge sys_clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("misplaced sync realigns", 1, rd[SB_REALIGN]);
        $display("sync input test done");
        conclude();
    end
endmodule
`default_nettype wire
